// ==== core/rwc_pkg.sv ====
// Shared constants and types for the reset and watchdog control block
package rwc_pkg;

   // ****************************************
   // Clock and time figures
   // ****************************************
   localparam int CLK_HZ       = 20_000_000;     // System clock rate
   localparam int DLY_LONG_MS  = 18;             // Crystal start delay, ms
   localparam int DLY_SHORT_US = 10;             // Non-crystal start delay, us
   localparam int WDT_BASE_MS  = 18;             // Watchdog base period, ms
   localparam int DLY_LONG_CYC  = DLY_LONG_MS * (CLK_HZ / 1000);
   localparam int DLY_SHORT_CYC = DLY_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int WDT_BASE_CYC  = WDT_BASE_MS * (CLK_HZ / 1000);

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] RWC_OPT_OFS = 8'h00;   // timer_watchdog_options
   localparam logic [7:0] RWC_ST_OFS  = 8'h04;   // Reset status
   localparam logic [7:0] RWC_CMD_OFS = 8'h08;   // Core command strobes
   localparam logic [7:0] RWC_MON_OFS = 8'h0C;   // Sequencer monitor

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int OPT_PSA_BIT   = 3;             // prescaler_select
   localparam int OPT_RATIO_MSB = 2;             // prescale_ratio_msb
   localparam int OPT_RATIO_LSB = 0;             // prescale_ratio_lsb
   localparam logic [7:0] OPT_RST = 8'hFF;       // Options after reset
   localparam int CMD_CLR_BIT   = 0;             // watchdog_clear_instr
   localparam int CMD_SLEEP_BIT = 1;             // Sleep instruction
   // Status bits 7..3 as one vector: wake pin, wake cmp, bit 5,
   // expiry_flag_n, sleep_flag_n
   localparam int UP_EXPIRY_IDX = 1;
   localparam int UP_SLEEP_IDX  = 0;
   localparam logic [4:0] ST_UP_POR       = 5'h03;   // 0001 1
   localparam logic [4:0] ST_UP_EXT_SLEEP = 5'h02;   // 0001 0
   localparam logic [4:0] ST_UP_WDT_SLEEP = 5'h00;   // 0000 0
   localparam logic [4:0] ST_UP_PIN_WAKE  = 5'h12;   // 1001 0
   localparam logic [4:0] ST_UP_CMP_WAKE  = 5'h0A;   // 0101 0

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      RWC_OSC_FAST_CRYSTAL,                      // fast_crystal_mode
      RWC_OSC_STD_CRYSTAL,                       // std_crystal_mode
      RWC_OSC_SLOW_CRYSTAL,                      // slow_crystal_mode
      RWC_OSC_EXT_CLOCK,                         // ext_clock_mode
      RWC_OSC_INTERNAL_RC,                       // internal_rc_mode
      RWC_OSC_EXTERNAL_RC                        // external_rc_mode
   } rwc_osc_t;

   typedef enum logic [1:0] {
      RWC_HOLD,                                  // Held by a reset source
      RWC_DELAY,                                 // start_delay_timer running
      RWC_RUN,                                   // Normal operation
      RWC_SLEEP                                  // Sleeping
   } rwc_state_t;

endpackage

// ==== core/rwc_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module rwc_sync3
   import rwc_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Pin side
   input  wire logic i_async,
   // Clean level
   output logic      o_level
);

   logic s1_q;                                   // Metastable stage
   logic s2_q;                                   // Second stage
   logic s3_q;                                   // Third stage

   // Shift chain; level follows once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q    <= RST_VAL;
         s2_q    <= RST_VAL;
         s3_q    <= RST_VAL;
         o_level <= RST_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end

endmodule

`default_nettype wire

// ==== core/rwc_top.sv ====
// Reset sequencer, start delay timer and watchdog with APB registers
//
// What this block does
// - Low status bits get no reset
// - Normal-run resets reload register reset values
// - Sleep ext/watchdog resets keep registers, resume
// - Power-on status upper bits read 0001 1
// - Running ext reset clears status bits 7..5
// - Sleep resets: ext 0001 0, watchdog 0000 0
// - Running watchdog reset clears 7..5 and expiry
// - Pin-change wake gives status 1001 0
// - Comparator wake gives status 0101 0
// - Fuse picks reset pin or plain input
// - Power-up sets latch; delay waits pin high
// - Delay expiry clears latch, releasing chip
// - Delay runs always, length by oscillator
// - Delay counts the system clock; core held meanwhile
// - 18 ms crystal, 10 us other modes
// - Watchdog wake from sleep starts delay
// - Delay follows every reset and wake source
// - Watchdog runs in sleep, timeout resets
// - Watchdog fuse zero disables it forever
// - 18 ms base, prescaler up to 1:128
// - Clear command zeroes count and prescaler
// - Option bit 3 selects, bits 2..0 ratio
// - Any wake from sleep clears watchdog
// - Brown-out during delay restarts the delay
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module rwc_top
   import rwc_pkg::*;
#(
   parameter int DLY_LONG_CYC_P = DLY_LONG_CYC,  // Long start delay, cycles
   parameter int WDT_BASE_CYC_P = WDT_BASE_CYC,  // Watchdog base, cycles
   parameter int ADDR_W         = 8              // APB address width
)(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Pins and supply monitor
   input  wire logic              i_ext_reset_n,
   input  wire logic              i_brown_out,
   // Configuration fuses
   input  wire logic              i_ext_reset_fuse,
   input  wire logic              i_watchdog_fuse,
   input  wire rwc_osc_t          i_osc_mode,
   // Wake sources from on-chip logic
   input  wire logic              i_pin_change_wake,
   input  wire logic              i_cmp_change_wake,
   // APB slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // Reset and state outputs
   output logic                   o_chip_reset,
   output logic                   o_regs_reset,
   output logic                   o_sleeping,
   output logic                   o_watchdog_timeout,
   output logic                   o_gp_input,
   output logic      [7:0]        o_status,
   output logic      [7:0]        o_option
);

   // ****************************************
   // Local sizes
   // ****************************************
   localparam int DLY_MAX = (DLY_LONG_CYC_P > DLY_SHORT_CYC) ?
                            DLY_LONG_CYC_P : DLY_SHORT_CYC;
   localparam int DCNT_W  = $clog2(DLY_MAX + 1);
   localparam int WCNT_W  = $clog2(WDT_BASE_CYC_P + 1);

   // ****************************************
   // Declarations
   // ****************************************
   rwc_state_t        state_q;                   // Sequencer state
   rwc_state_t        state_d;                   // Next state
   logic              pin_s;                     // Synced reset pin
   logic              bo_s;                      // Synced brown-out
   logic [DCNT_W-1:0] dcnt_q;                    // start_delay_timer count
   logic [DCNT_W-1:0] dly_lim;                   // Last delay count
   logic [WCNT_W-1:0] wcnt_q;                    // Watchdog base count
   logic [6:0]        pre_q;                     // Watchdog prescaler
   logic [7:0]        pre_mask8;                 // 2^n - 1, wide
   logic [6:0]        pre_mask;                  // Prescaler last count
   logic [4:0]        st_up_q;                   // Status bits 7..3
   logic [4:0]        st_up_d;                   // Next status bits 7..3
   logic [2:0]        st_low_q;                  // Status bits 2..0
   logic [7:0]        opt_q;                     // Option register
   logic [31:0]       rdata_d;                   // Read mux
   logic              regs_rst_q;                // Register reset pulse
   logic              wdt_to_q;                  // Timeout pulse copy

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Pin starts low so the delay waits until a real high is seen
   rwc_sync3 #(.RST_VAL(1'b0)) u_pin_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_ext_reset_n),
      .o_level (pin_s)
   );

   rwc_sync3 #(.RST_VAL(1'b0)) u_bo_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_brown_out),
      .o_level (bo_s)
   );

   // ****************************************
   // Reset sources and wake events
   // ****************************************
   wire ext_low   = i_ext_reset_fuse & ~pin_s;
   wire hold_src  = bo_s | ext_low;              // Sources that hold reset
   wire in_run    = (state_q == RWC_RUN);
   wire in_sleep  = (state_q == RWC_SLEEP);
   wire active    = in_run | in_sleep;
   wire ext_evt   = ext_low & active;            // Pin reset while live
   wire pin_wake  = in_sleep & i_pin_change_wake;
   wire cmp_wake  = in_sleep & i_cmp_change_wake & ~i_pin_change_wake;
   wire any_wake  = pin_wake | cmp_wake;

   // ****************************************
   // APB decode
   // ****************************************
   wire apb_setup = i_psel & ~i_penable;
   wire apb_acc   = i_psel & i_penable;
   wire apb_wr    = apb_acc & i_pwrite;
   wire sel_opt   = (i_paddr == ADDR_W'(RWC_OPT_OFS));
   wire sel_st    = (i_paddr == ADDR_W'(RWC_ST_OFS));
   wire sel_cmd   = (i_paddr == ADDR_W'(RWC_CMD_OFS));
   wire sel_mon   = (i_paddr == ADDR_W'(RWC_MON_OFS));
   wire mapped    = sel_opt | sel_st | sel_cmd | sel_mon;
   wire wr_opt    = apb_wr & sel_opt;
   wire wr_st     = apb_wr & sel_st;
   wire wr_cmd    = apb_wr & sel_cmd;
   wire clr_cmd   = wr_cmd & i_pwdata[CMD_CLR_BIT];
   wire sleep_cmd = wr_cmd & i_pwdata[CMD_SLEEP_BIT] & in_run;

   // Zero wait states; unmapped access answers with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = apb_acc & ~mapped;

   // ****************************************
   // Watchdog timer
   // ****************************************
   wire prescaler_select       = opt_q[OPT_PSA_BIT];
   wire [2:0] ratio = opt_q[OPT_RATIO_MSB:OPT_RATIO_LSB];
   // Base count only while live and fused on; it keeps going in sleep
   wire wdt_run   = i_watchdog_fuse & active;
   wire wdt_clr   = ~wdt_run | clr_cmd | sleep_cmd | any_wake;
   wire base_wrap = wdt_run & (wcnt_q == WCNT_W'(WDT_BASE_CYC_P - 1));
   assign pre_mask8 = (8'h01 << ratio) - 8'h01;
   assign pre_mask  = pre_mask8[6:0];
   wire wdt_to    = base_wrap & (~prescaler_select | (pre_q == pre_mask));

   // Base counter on the watchdog time base
   always_ff @(posedge i_clk) begin
      if (i_rst || wdt_clr || base_wrap) begin
         wcnt_q <= '0;
      end else begin
         wcnt_q <= wcnt_q + 1'b1;
      end
   end

   // Prescaler, only in use while assigned to the watchdog
   always_ff @(posedge i_clk) begin
      if (i_rst || wdt_clr || !prescaler_select || wdt_to) begin
         pre_q <= '0;
      end else if (base_wrap) begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // ****************************************
   // Start delay timer
   // ****************************************
   // Crystal modes need the long delay, all others the short one
   wire crystal = (i_osc_mode == RWC_OSC_FAST_CRYSTAL) ||
                  (i_osc_mode == RWC_OSC_STD_CRYSTAL)  ||
                  (i_osc_mode == RWC_OSC_SLOW_CRYSTAL);
   assign dly_lim = crystal ? DCNT_W'(DLY_LONG_CYC_P - 1) :
                              DCNT_W'(DLY_SHORT_CYC - 1);
   wire dly_done = (state_q == RWC_DELAY) && (dcnt_q == dly_lim);

   // Counts only in the delay state; any hold source restarts it
   always_ff @(posedge i_clk) begin
      if (i_rst || state_q != RWC_DELAY) begin
         dcnt_q <= '0;
      end else begin
         dcnt_q <= dcnt_q + 1'b1;
      end
   end

   // ****************************************
   // Reset sequencer
   // ****************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         // Wait for pin high and supply good
         RWC_HOLD: begin
            if (!hold_src) begin
               state_d = RWC_DELAY;
            end
         end
         // Delay running; brown-out or pin restarts it
         RWC_DELAY: begin
            if (hold_src) begin
               state_d = RWC_HOLD;
            end else if (dly_done) begin
               state_d = RWC_RUN;
            end
         end
         // Normal operation
         RWC_RUN: begin
            if (hold_src) begin
               state_d = RWC_HOLD;
            end else if (wdt_to) begin
               state_d = RWC_DELAY;
            end else if (sleep_cmd) begin
               state_d = RWC_SLEEP;
            end
         end
         // Sleep; every wake passes through the delay
         RWC_SLEEP: begin
            if (hold_src) begin
               state_d = RWC_HOLD;
            end else if (wdt_to || any_wake) begin
               state_d = RWC_DELAY;
            end
         end
      endcase
   end

   // State register; power-on sets the reset latch
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= RWC_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // Core held while latched or the delay runs
   assign o_chip_reset = (state_q == RWC_HOLD) || (state_q == RWC_DELAY);
   assign o_sleeping   = in_sleep;

   // ****************************************
   // Status register
   // ****************************************
   // Software writes bits 7..5; hardware events win over the write
   always_comb begin
      st_up_d = st_up_q;
      if (wr_st) begin
         st_up_d[4:2] = i_pwdata[7:5];
      end
      if (bo_s) begin
         st_up_d = ST_UP_POR;
      end else if (ext_evt && in_sleep) begin
         st_up_d = ST_UP_EXT_SLEEP;
      end else if (ext_evt) begin
         st_up_d[4:2] = 3'h0;
      end else if (wdt_to && in_sleep) begin
         st_up_d = ST_UP_WDT_SLEEP;
      end else if (wdt_to) begin
         st_up_d[4:2] = 3'h0;
         st_up_d[UP_EXPIRY_IDX] = 1'b0;
      end else if (pin_wake) begin
         st_up_d = ST_UP_PIN_WAKE;
      end else if (cmp_wake) begin
         st_up_d = ST_UP_CMP_WAKE;
      end else if (sleep_cmd) begin
         st_up_d[UP_EXPIRY_IDX] = 1'b1;
         st_up_d[UP_SLEEP_IDX]  = 1'b0;
      end
   end

   // Upper status bits reset only on power-on
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_up_q <= ST_UP_POR;
      end else begin
         st_up_q <= st_up_d;
      end
   end

   // Low bits keep their value through every reset
   always_ff @(posedge i_clk) begin
      if (wr_st) begin
         st_low_q <= i_pwdata[2:0];
      end
   end

   assign o_status = {st_up_q, st_low_q};

   // ****************************************
   // Option register and register reset
   // ****************************************
   // Running resets and wakes reload; sleep ext/wdt resets do not
   wire regs_rst = bo_s | ((ext_evt | wdt_to) & in_run) | any_wake;

   // Reset beats a same-cycle write
   always_ff @(posedge i_clk) begin
      if (i_rst || regs_rst) begin
         opt_q <= OPT_RST;
      end else if (wr_opt) begin
         opt_q <= i_pwdata[7:0];
      end
   end

   assign o_option = opt_q;

   // Pulses to the rest of the chip
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         regs_rst_q <= 1'b1;
         wdt_to_q   <= 1'b0;
      end else begin
         regs_rst_q <= regs_rst;
         wdt_to_q   <= wdt_to;
      end
   end

   assign o_regs_reset       = regs_rst_q;
   assign o_watchdog_timeout = wdt_to_q;
   assign o_gp_input         = pin_s;

   // ****************************************
   // Read data
   // ****************************************
   assign rdata_d = sel_opt ? {24'h00_0000, opt_q} :
                    sel_st  ? {24'h00_0000, o_status} :
                    sel_mon ? {23'h00_0000, pre_q, in_sleep, o_chip_reset} :
                              32'h0000_0000;

   // Captured in the setup phase, stable through the access
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (apb_setup && !i_pwrite) begin
         o_prdata <= rdata_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_por_pattern: assert property (disable iff (1'b0)
      i_rst |=> (o_status[7:3] == ST_UP_POR) && o_chip_reset)
      else $error("power-on status or latch wrong");

   a_release_count: assert property (
      $fell(o_chip_reset) |-> ($past(dcnt_q) == dly_lim) &&
                              ($past(state_q) == RWC_DELAY))
      else $error("released before full delay");

   a_pin_holds: assert property (
      ext_low |=> o_chip_reset [*2])
      else $error("pin low did not hold reset");

   a_pin_off: assert property (
      !i_ext_reset_fuse && in_run && !bo_s && !wdt_to |=> !o_chip_reset)
      else $error("pin reset active with fuse off");

   a_fuse_off: assert property (
      !i_watchdog_fuse |-> !wdt_to ##1 (wcnt_q == '0))
      else $error("watchdog ran with fuse off");

   a_clear_zeroes: assert property (
      clr_cmd && in_run && !hold_src |=> (wcnt_q == '0) && (pre_q == '0))
      else $error("clear did not zero watchdog");

   a_sleep_entry: assert property (
      sleep_cmd && !hold_src && !wdt_to |=> in_sleep && (wcnt_q == '0) &&
                                        (o_status[4:3] == 2'b10))
      else $error("sleep entry wrong");

   a_wdt_sleep: assert property (
      wdt_to && in_sleep && !hold_src |=>
         (o_status[7:3] == ST_UP_WDT_SLEEP) && (state_q == RWC_DELAY) &&
         !o_regs_reset)
      else $error("sleep watchdog wake wrong");

   a_wdt_run: assert property (
      wdt_to && in_run && !hold_src |=> (o_status[7:5] == 3'h0) &&
         !o_status[4] && (o_status[3] == $past(o_status[3])) && o_regs_reset)
      else $error("running watchdog reset wrong");

   a_ext_run: assert property (
      ext_evt && in_run && !bo_s |=> (o_status[7:5] == 3'h0) &&
         (o_status[4:3] == $past(o_status[4:3])))
      else $error("running pin reset status wrong");

   a_pin_wake: assert property (
      pin_wake && !hold_src |=> (o_status[7:3] == ST_UP_PIN_WAKE) &&
                                o_chip_reset && (wcnt_q == '0))
      else $error("pin wake wrong");

   a_cmp_wake: assert property (
      cmp_wake && !hold_src |=> (o_status[7:3] == ST_UP_CMP_WAKE))
      else $error("comparator wake wrong");

   c_release:   cover property ($fell(o_chip_reset));
   c_sleep:     cover property (sleep_cmd);
   c_wdt_wake:  cover property (wdt_to && in_sleep);
   c_pin_wake:  cover property (pin_wake);

endmodule

`default_nettype wire

// ==== sim/rwc_pin_model.sv ====
// Reset pin partner: pin with pull-up, pulled low on request
`timescale 1ns/10ps
`default_nettype none

module rwc_pin_model (
   // Clock
   input  wire logic i_clk,
   // Request to pull the pin low
   input  wire logic i_hold,
   // Pin level seen by the block
   output logic      o_pin_n
);
   // Pull-up restores a high level at the first clock edge after the pin is released
   initial o_pin_n = 1'b1;

   // Pin moves only just after an edge
   always @(posedge i_clk) begin
      o_pin_n <= ~i_hold;
   end
endmodule

`default_nettype wire

// ==== sim/rwc_top_tb.sv ====
// Self-checking bench for the reset and watchdog control block
`timescale 1ns/10ps
`default_nettype none

module rwc_top_tb;
   import rwc_pkg::*;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic clk = 0, rst = 1, hold = 1, bo = 0, efuse = 1, wfuse = 1;
   logic pw = 0, cw = 0, psel = 0, pen = 0, pwr = 0, serr;
   rwc_osc_t osc = RWC_OSC_FAST_CRYSTAL;
   logic [7:0] pa = 0, sv;
   logic [31:0] pd = 0, rd;
   wire logic pin_n, rdy, perr, crst, slp, wto, gp, rrst;
   wire logic [31:0] prd;
   wire logic [7:0] st, opt;
   int errors = 0, n_checks = 0, cyc = 0, n_wto = 0, n_rr = 0, n;

   always #25 clk = ~clk;

   rwc_pin_model u_pin (.i_clk(clk), .i_hold(hold), .o_pin_n(pin_n));

   rwc_top #(.DLY_LONG_CYC_P(256), .WDT_BASE_CYC_P(64)) u_dut (
      .i_clk(clk), .i_rst(rst), .i_ext_reset_n(pin_n), .i_brown_out(bo),
      .i_ext_reset_fuse(efuse), .i_watchdog_fuse(wfuse), .i_osc_mode(osc),
      .i_pin_change_wake(pw), .i_cmp_change_wake(cw), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd),
      .o_prdata(prd), .o_pready(rdy), .o_pslverr(perr), .o_chip_reset(crst),
      .o_regs_reset(rrst), .o_sleeping(slp), .o_watchdog_timeout(wto),
      .o_gp_input(gp), .o_status(st), .o_option(opt));

   // Cycle ceiling and timeout pulse tally
   always @(posedge clk) begin
      cyc++;
      if (wto === 1'b1) n_wto++;
      if (rrst === 1'b1) n_rr++;
      if (cyc == 30000) begin
         errors++;
         end_sim;
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwr <= w; pa <= a; pd <= d;
      @(posedge clk) pen <= 1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prd;
      serr = perr;
      psel <= 0; pen <= 0;
      @(posedge clk);
   endtask

   // Cycles until the core is let go
   task automatic rel;
      n = 0;
      while (crst !== 1'b0) begin
         @(posedge clk);
         n++;
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_por;
      repeat (5) @(posedge clk);
      chk("por_st", st[7:3], 5'b00011);
      chk("por_opt", opt, 8'hFF);
      rst <= 0;
      repeat (20) @(posedge clk);
      chk("pin_low_hold", crst, 1);
      hold <= 0;
      rel;
      chk("por_dly", n >= 256 && n <= 266, 1);
   endtask

   task automatic t_apb;
      apb(1, RWC_OPT_OFS, 32'h0000_00A5);
      apb(0, RWC_OPT_OFS, 0);
      chk("opt_rd", rd, 32'h0000_00A5);
      apb(0, 8'h10, 32'h0000_0000);
      chk("unmapped", serr, 1);
   endtask

   // Running watchdog expiry with a given option value
   task automatic t_wdt(input logic [7:0] o, input int e);
      apb(1, RWC_OPT_OFS, {24'h0, o});
      apb(1, RWC_ST_OFS, 32'h0000_00E5);
      apb(1, RWC_CMD_OFS, 32'h0000_0001);
      n = 0;
      while (wto !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("wdt_period", n >= e - 3 && n <= e + 3, 1);
      rel;
      chk("wdt_run_st", st, 8'h0D);
      chk("wdt_run_opt", opt, 8'hFF);
   endtask

   task automatic t_clr;
      apb(1, RWC_OPT_OFS, 32'h0000_0000);
      n_wto = 0;
      repeat (5) begin
         repeat (40) @(posedge clk);
         apb(1, RWC_CMD_OFS, 32'h0000_0001);
      end
      chk("clr_no_to", n_wto, 0);
   endtask

   // Sleep, then a wake source: 0 pin reset, 1 pin change, 2 comparator, 3 watchdog
   task automatic t_sleep(input int src, input logic [4:0] e);
      apb(1, RWC_OPT_OFS, 32'h0000_0000);
      apb(1, RWC_CMD_OFS, 32'h0000_0002);
      while (slp !== 1'b1) @(posedge clk);
      chk("sleep_flags", st[4:3], 2'b10);
      n_rr = 0;
      if (src == 0) hold <= 1;
      if (src == 1) pw <= 1;
      if (src == 2) cw <= 1;
      while (crst !== 1'b1) @(posedge clk);
      hold <= 0; pw <= 0; cw <= 0;
      rel;
      chk("wake_st", st[7:3], e);
      if (src == 0 || src == 3) chk("sleep_keep", opt, 8'h00);
      chk("wake_reload", n_rr, (src == 1 || src == 2));
   endtask

   // Brown-out, then a second one inside the start delay
   task automatic t_bo;
      osc <= RWC_OSC_FAST_CRYSTAL;
      bo <= 1;
      while (crst !== 1'b1) @(posedge clk);
      bo <= 0;
      repeat (60) @(posedge clk);
      bo <= 1;
      repeat (10) @(posedge clk);
      bo <= 0;
      rel;
      chk("bo_dly", n >= 256 && n <= 266, 1);
      chk("bo_st", st[7:3], 5'b00011);
      chk("bo_opt", opt, 8'hFF);
   endtask

   // Running pin reset in every oscillator mode
   task automatic t_ext;
      for (int i = 0; i < 6; i++) begin
         osc <= rwc_osc_t'(i);
         apb(1, RWC_ST_OFS, 32'h0000_00E5);
         sv = st;
         hold <= 1;
         while (crst !== 1'b1) @(posedge clk);
         hold <= 0;
         rel;
         chk("ext_st", st, {3'b000, sv[4:0]});
         chk("ext_dly", n >= (i < 3 ? 256 : 200) && n <= (i < 3 ? 266 : 210), 1);
      end
   endtask

   task automatic t_fuse;
      efuse <= 0;
      hold <= 1;
      repeat (12) @(posedge clk);
      chk("fuse_no_rst", crst, 0);
      chk("gp_low", gp, 0);
      hold <= 0;
      wfuse <= 0;
      apb(1, RWC_OPT_OFS, 32'h0000_0000);
      n_wto = 0;
      repeat (300) @(posedge clk);
      chk("wdt_off", n_wto, 0);
   endtask

   initial begin
      t_por;
      t_apb;
      t_wdt(8'h00, 64);
      t_wdt(8'h09, 128);
      t_clr;
      t_sleep(0, 5'b00010);
      t_sleep(3, 5'b00000);
      t_sleep(1, 5'b10010);
      t_sleep(2, 5'b01010);
      t_ext;
      t_fuse;
      t_bo;
      end_sim;
   end
endmodule

`default_nettype wire
